// *** core/nibble_cpu_pkg.sv ***
// Constants for the 4-bit control microcomputer decode and execute block.
// Assumes a single system clock; every opcode, leading nibble and selector the decoder compares against is named here.
package nibble_cpu_pkg;
  localparam int PC_W = 12;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [3:0]  NIB_ZERO = 4'h0;
  localparam logic [3:0]  NIB_ONE  = 4'h1;
  // Whole-byte opcodes
  localparam logic [7:0] OP_IDLE        = 8'h00;
  localparam logic [7:0] OP_PORT_READ   = 8'h0C;
  localparam logic [7:0] OP_PORT_WRITE  = 8'h61;
  localparam logic [7:0] OP_SUB_RET     = 8'h62;
  localparam logic [7:0] OP_IRQ_RET     = 8'h22;
  localparam logic [7:0] OP_SWAP_ACC_PH = 8'h23;
  localparam logic [7:0] OP_PTR_LOW_INC = 8'hEE;
  localparam logic [7:0] OP_PTR_LOW_DEC = 8'hEF;
  localparam logic [7:0] OP_ACC_TO_PL   = 8'hF7;
  localparam logic [7:0] OP_PL_TO_ACC   = 8'hE9;
  localparam logic [7:0] OP_PAGE_JUMP   = 8'hFA;
  localparam logic [7:0] OP_TIMER_LOAD  = 8'hF9;
  localparam logic [7:0] OP_HALT        = 8'hF6;
  localparam logic [7:0] OP_CTRL_PFX    = 8'h2C;
  localparam logic [7:0] OP_SWAP_PH_S0  = 8'hF8;
  localparam logic [7:0] OP_SWAP_PH_S1  = 8'hFC;
  localparam logic [7:0] OP_SWAP_PL_S0  = 8'hF0;
  localparam logic [7:0] OP_SWAP_PL_S1  = 8'hF4;
  // Leading nibbles, swap select low bits, port-bit prefixes and one-byte jump range
  localparam logic [3:0] NB_PTR_ZERO_HIGH = 4'h8;
  localparam logic [3:0] NB_PTR_HIGH_IMM  = 4'h4;
  localparam logic [3:0] NB_FLAG_SET      = 4'h5;
  localparam logic [3:0] NB_FLAG_CLR      = 4'h1;
  localparam logic [3:0] NB_JUMP          = 4'h6;
  localparam logic [3:0] NB_CALL          = 4'hA;
  localparam logic [3:0] NB_PAGE0_CALL    = 4'hB;
  localparam logic [3:0] NB_BR_ONE        = 4'h7;
  localparam logic [3:0] NB_BR_ZERO       = 4'h3;
  localparam logic [3:0] NB_BF_SET        = 4'hD;
  localparam logic [3:0] NB_BF_CLR        = 4'h9;
  localparam logic [3:0] NB_LOAD_IMM      = 4'hC;
  localparam logic [3:0] NB_SWAP_ACC      = 4'hE;
  localparam logic [1:0] SWAP_ACC_LOW     = 2'h0;
  localparam logic [5:0] PFX_PORT_BIT_SET = 6'h01;
  localparam logic [5:0] PFX_PORT_BIT_CLR = 6'h09;
  localparam logic [7:0] JUMP_ONE_BYTE_LO = 8'h60;
  localparam logic [7:0] JUMP_ONE_BYTE_HI = 8'h63;
  // Branch second-byte selectors
  localparam logic [1:0] BR_ACC      = 2'h0;
  localparam logic [1:0] BR_MEM      = 2'h1;
  localparam logic [1:0] BR_PORT     = 2'h2;
  localparam logic [3:0] BR_TICK     = 4'hC;
  localparam logic [3:0] BR_PIN_IRQ  = 4'hD;
  localparam logic [3:0] BR_ZERO_F   = 4'hE;
  localparam logic [3:0] BR_CARRY_F  = 4'hF;
  // Control mask second-byte selectors; return stack depth
  localparam logic [3:0] CTRL_SEL_SET = 4'h4;
  localparam logic [3:0] CTRL_SEL_CLR = 4'h5;
  localparam int STACK_DEPTH = 8;
endpackage : nibble_cpu_pkg

// *** core/return_stack.sv ***
// Last-in first-out store of return addresses in flip-flops.
// Assumes push and pop never coincide; overflow wraps and overwrites oldest.
module return_stack #(
  parameter int DEPTH = 8,
  parameter int W     = 12
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_data,
  output logic      [W-1:0] top
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] sp_r;
  logic [PW-1:0] sp_dec;

  assign sp_dec = sp_r - 1'b1;
  assign top    = mem_r[sp_dec];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sp_r <= '0;
    end else if (push) begin
      mem_r[sp_r] <= push_data;
      sp_r        <= sp_r + 1'b1;
    end else if (pop) begin
      sp_r <= sp_dec;
    end
  end
endmodule : return_stack

// *** core/general_flags.sv ***
// Sixteen single-bit general flags with set and clear by index.
// Assumes set and clear are never requested together.
module general_flags (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        set_en,
  input  wire logic        clr_en,
  input  wire logic [3:0]  idx,
  output logic      [15:0] flags,
  output logic             group_zero
);
  logic [15:0] flags_r;
  logic [3:0]  group;
  logic [3:0]  group_after;

  assign flags       = flags_r;
  assign group       = flags_r[{idx[3:2], 2'b00} +: 4];
  assign group_after = group & ~(4'b0001 << idx[1:0]);
  assign group_zero  = (group_after == 4'h0);

  for (genvar i = 0; i < 16; i++) begin : g_flag
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        flags_r[i] <= 1'b0;
      end else if (idx == 4'(i)) begin
        if (set_en) begin
          flags_r[i] <= 1'b1;
        end else if (clr_en) begin
          flags_r[i] <= 1'b0;
        end
      end
    end
  end
endmodule : general_flags

// *** core/nibble_cpu_instruction_decoder.sv ***
// Decode and execute of pointer, flag, jump, branch, port and misc ops.
// Assumes program ROM and data RAM answer combinationally to the address
// outputs, and port read data is valid for port_sel in the same cycle.
// Behaviour
// [RULE_01] High nibble 8 zeroes pointer high, loads pointer low; nibble 4 loads pointer high.
// [RULE_02] EE increments and EF decrements pointer low, one cycle, zero flag updated.
// [RULE_03] F7 copies accumulator to pointer low; E9 copies back and updates zero.
// [RULE_04] E with select swaps accumulator with scratch A; 23 swaps with pointer high.
// [RULE_05] F8 and FC swap pointer high with H0/H1; F0 and F4 pointer low with L0/L1.
// [RULE_06] High nibble 5 sets and 1 clears the indexed general flag.
// [RULE_07] On clear, zero flag reflects the flag's group of four after clearing.
// [RULE_08] Two-byte jump keeps PC bit 11 and loads bits 10 to 0.
// [RULE_09] FA loads PC bits 7 to 0 from extension and accumulator.
// [RULE_10] High nibble B pushes PC plus one and calls page zero slot.
// [RULE_11] Two-byte call pushes PC plus two, clears bit 11, loads the rest.
// [RULE_12] 62 pops PC; 22 also pops and restores carry and zero copies.
// [RULE_13] Branch selects accumulator, memory or port bit; 7 on one, 3 on zero.
// [RULE_14] Taken branch replaces PC bits 7 to 0; both outcomes take two cycles.
// [RULE_15] Tick and pin interrupt flag branches clear the tested flag always.
// [RULE_16] Carry and zero flag branches test without modifying the flag.
// [RULE_17] Leading D branches on general flag set, 9 on clear.
// [RULE_18] 0C reads addressed port into accumulator; 61 writes accumulator to it.
// [RULE_19] Port bit set and clear take two cycles; clear updates zero, spoils extension.
// [RULE_20] Control mask set ORs, clear ANDs off bits with zero update; two cycles.
// [RULE_21] F9 loads timer from extension and accumulator and clears tick flag.
// [RULE_22] 00 idles one cycle; F6 halts until woken.
// [RULE_23] Repeated immediate loads or accumulator clears: only the first takes effect.
// [RULE_24] Return stack holds eight entries, last in first out.
module nibble_cpu_instruction_decoder
  import nibble_cpu_pkg::*;
#(
  parameter int STACK_LEVELS = STACK_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         ce,
  output logic [PC_W-1:0]   rom_addr,
  input  wire logic [7:0]   rom_data,
  output logic [7:0]        ram_addr,
  input  wire logic [3:0]   ram_rdata,
  output logic [3:0]        port_sel,
  input  wire logic [3:0]   port_rdata,
  output logic [3:0]        port_wdata,
  output logic              port_wr,
  output logic [3:0]        control_bits,
  output logic [7:0]        timer_value,
  output logic              timer_wr,
  input  wire logic         tick_ovf,
  input  wire logic         saved_carry,
  input  wire logic         saved_zero,
  input  wire logic         pin_irq,
  input  wire logic         wake,
  output logic              halted,
  output logic              tick_overflow_flag,
  output logic              pin_irq_flag,
  output logic              carry_flag,
  output logic              zero_flag,
  output logic [3:0]        work_nibble_reg,
  output logic [15:0]       gen_flags
);
  typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_WAIT, ST_HALT} state_t;

  state_t          state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0]      first_r, first_nxt;
  logic [3:0]      acc_r, acc_nxt;
  logic [3:0]      ext_r, ext_nxt;
  logic [3:0]      ph_r, ph_nxt;
  logic [3:0]      pl_r, pl_nxt;
  logic [3:0]      scr_a_r [4];
  logic [3:0]      scr_a_nxt [4];
  logic [3:0]      scr_h_r [2];
  logic [3:0]      scr_h_nxt [2];
  logic [3:0]      scr_l_r [2];
  logic [3:0]      scr_l_nxt [2];
  logic            carry_r, carry_nxt;
  logic            zero_r, zero_nxt;
  logic            tick_r, tick_nxt;
  logic            irq_r, irq_nxt;
  logic [3:0]      ctl_r, ctl_nxt;
  logic [3:0]      pwdata_r, pwdata_nxt;
  logic            pwr_r, pwr_nxt;
  logic [7:0]      tval_r, tval_nxt;
  logic            twr_r, twr_nxt;
  logic            run_r, run_nxt;
  logic [2:0]      irq_sync_r;
  logic [1:0]      wake_sync_r;

  // Pins pass two stages; edge detect looks only at the settled stages
  logic            irq_edge;
  logic            wake_s;
  logic [3:0]      op_hi;
  logic [3:0]      op_lo;
  logic [3:0]      b1_lo;
  logic [3:0]      b2_hi;
  logic [3:0]      b2_lo;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] stack_top;
  logic            push, pop;
  logic [PC_W-1:0] push_val;
  logic            fset, fclr;
  logic [3:0]      fidx;
  logic            group_zero;
  logic            two_byte;
  logic            is_jump_exempt;
  logic            cond;
  logic            taken;
  logic [3:0]      pl_step;
  logic [3:0]      bit_mask;
  logic [3:0]      port_clr_val;

  assign irq_edge       = irq_sync_r[1] & ~irq_sync_r[2];
  assign wake_s         = wake_sync_r[1];
  assign op_hi          = rom_data[7:4];
  assign op_lo          = rom_data[3:0];
  assign b1_lo          = first_r[3:0];
  assign b2_hi          = rom_data[7:4];
  assign b2_lo          = rom_data[3:0];
  assign pc_inc         = pc_r + 1'b1;
  assign is_jump_exempt = (rom_data >= JUMP_ONE_BYTE_LO) && (rom_data <= JUMP_ONE_BYTE_HI);
  assign two_byte       = (op_hi == NB_JUMP && !is_jump_exempt) || op_hi == NB_CALL
                          || op_hi == NB_BR_ONE || op_hi == NB_BR_ZERO
                          || op_hi == NB_BF_SET || op_hi == NB_BF_CLR
                          || rom_data == OP_CTRL_PFX;
  assign pl_step        = (rom_data == OP_PTR_LOW_INC) ? pl_r + 1'b1 : pl_r - 1'b1;
  assign bit_mask       = 4'b0001 << op_lo[1:0];
  assign port_clr_val   = port_rdata & ~bit_mask;

  // Branch condition from the second byte
  always_comb begin
    cond = 1'b0;
    if (first_r[7:4] == NB_BF_SET || first_r[7:4] == NB_BF_CLR) begin
      cond = gen_flags[b2_hi];                                  // [RULE_17]
    end else begin
      unique case (b2_hi[3:2])
        BR_ACC:  cond = acc_r[b2_hi[1:0]];                      // [RULE_13]
        BR_MEM:  cond = ram_rdata[b2_hi[1:0]];                  // [RULE_13]
        BR_PORT: cond = port_rdata[b2_hi[1:0]];                 // [RULE_13]
        default: begin
          unique case (b2_hi)
            BR_TICK:    cond = tick_r;                          // [RULE_15]
            BR_PIN_IRQ: cond = irq_r;                           // [RULE_15]
            BR_ZERO_F:  cond = zero_r;                          // [RULE_16]
            default:    cond = carry_r;                         // [RULE_16]
          endcase
        end
      endcase
    end
  end
  assign taken = (first_r[7:4] == NB_BR_ONE || first_r[7:4] == NB_BF_SET) ? cond : !cond;

  always_comb begin
    state_nxt  = state_r;
    pc_nxt     = pc_r;
    first_nxt  = first_r;
    acc_nxt    = acc_r;
    ext_nxt    = ext_r;
    ph_nxt     = ph_r;
    pl_nxt     = pl_r;
    scr_a_nxt  = scr_a_r;
    scr_h_nxt  = scr_h_r;
    scr_l_nxt  = scr_l_r;
    carry_nxt  = carry_r;
    zero_nxt   = zero_r;
    tick_nxt   = tick_r;
    irq_nxt    = irq_r;
    ctl_nxt    = ctl_r;
    pwdata_nxt = pwdata_r;
    pwr_nxt    = 1'b0;
    tval_nxt   = tval_r;
    twr_nxt    = 1'b0;
    run_nxt    = run_r;
    push       = 1'b0;
    pop        = 1'b0;
    push_val   = pc_inc;
    fset       = 1'b0;
    fclr       = 1'b0;
    fidx       = op_lo;
    unique case (state_r)
      ST_HALT: begin
        if (wake_s) begin
          state_nxt = ST_EXEC;                                  // [RULE_22]
        end
      end
      ST_WAIT: begin
        state_nxt = ST_EXEC;                                    // [RULE_19]
      end
      ST_SECOND: begin
        state_nxt = ST_EXEC;
        pc_nxt    = pc_inc;
        run_nxt   = 1'b0;
        if (first_r[7:4] == NB_JUMP) begin
          pc_nxt = {pc_r[11], rom_data[6:4], b1_lo, b2_lo};     // [RULE_08]
        end else if (first_r[7:4] == NB_CALL) begin
          push   = 1'b1;                                        // [RULE_11]
          pc_nxt = {1'b0, rom_data[6:4], b1_lo, b2_lo};         // [RULE_11]
        end else if (first_r == OP_CTRL_PFX) begin
          if (b2_hi == CTRL_SEL_SET) begin
            ctl_nxt = ctl_r | b2_lo;                            // [RULE_20]
          end else if (b2_hi == CTRL_SEL_CLR) begin
            ctl_nxt  = ctl_r & ~b2_lo;                          // [RULE_20]
            zero_nxt = ((ctl_r & ~b2_lo) == NIB_ZERO);          // [RULE_20]
          end
        end else begin
          if (taken) begin
            pc_nxt = {pc_r[11:8], b1_lo, b2_lo};                // [RULE_14]
          end
          if (first_r[7:4] == NB_BR_ONE || first_r[7:4] == NB_BR_ZERO) begin
            if (b2_hi == BR_TICK) begin
              tick_nxt = 1'b0;                                  // [RULE_15]
            end else if (b2_hi == BR_PIN_IRQ) begin
              irq_nxt = 1'b0;                                   // [RULE_15]
            end
          end
        end
      end
      ST_EXEC: begin
        pc_nxt  = pc_inc;
        run_nxt = 1'b0;
        if (two_byte) begin
          first_nxt = rom_data;
          state_nxt = ST_SECOND;
        end else if (op_hi == NB_LOAD_IMM) begin
          run_nxt = 1'b1;
          if (!run_r) begin
            acc_nxt  = op_lo;                                   // [RULE_23]
            zero_nxt = (op_lo == NIB_ZERO);
          end
        end else if (op_hi == NB_PTR_ZERO_HIGH) begin
          ph_nxt = NIB_ZERO;                                    // [RULE_01]
          pl_nxt = op_lo;                                       // [RULE_01]
        end else if (op_hi == NB_PTR_HIGH_IMM) begin
          ph_nxt = op_lo;                                       // [RULE_01]
        end else if (op_hi == NB_FLAG_SET) begin
          fset = 1'b1;                                          // [RULE_06]
        end else if (op_hi == NB_FLAG_CLR) begin
          fclr     = 1'b1;                                      // [RULE_06]
          zero_nxt = group_zero;                                // [RULE_07]
        end else if (op_hi == NB_PAGE0_CALL) begin
          push   = 1'b1;                                        // [RULE_10]
          pc_nxt = {6'h00, op_lo, 2'b00};                       // [RULE_10]
        end else if (op_hi == NB_SWAP_ACC && op_lo[1:0] == SWAP_ACC_LOW) begin
          acc_nxt                = scr_a_r[op_lo[3:2]];         // [RULE_04]
          scr_a_nxt[op_lo[3:2]]  = acc_r;                       // [RULE_04]
        end else if (rom_data[7:2] == PFX_PORT_BIT_SET) begin
          pwdata_nxt = port_rdata | bit_mask;                   // [RULE_19]
          pwr_nxt    = 1'b1;
          state_nxt  = ST_WAIT;                                 // [RULE_19]
        end else if (rom_data[7:2] == PFX_PORT_BIT_CLR) begin
          pwdata_nxt = port_clr_val;                            // [RULE_19]
          pwr_nxt    = 1'b1;
          zero_nxt   = (port_clr_val == NIB_ZERO);              // [RULE_19]
          ext_nxt    = port_rdata;                              // [RULE_19]
          state_nxt  = ST_WAIT;                                 // [RULE_19]
        end else begin
          unique case (rom_data)
            OP_PTR_LOW_INC, OP_PTR_LOW_DEC: begin
              pl_nxt   = pl_step;                               // [RULE_02]
              zero_nxt = (pl_step == NIB_ZERO);                 // [RULE_02]
            end
            OP_ACC_TO_PL: pl_nxt = acc_r;                       // [RULE_03]
            OP_PL_TO_ACC: begin
              acc_nxt  = pl_r;                                  // [RULE_03]
              zero_nxt = (pl_r == NIB_ZERO);                    // [RULE_03]
            end
            OP_SWAP_ACC_PH: begin
              acc_nxt = ph_r;                                   // [RULE_04]
              ph_nxt  = acc_r;                                  // [RULE_04]
            end
            OP_SWAP_PH_S0, OP_SWAP_PH_S1: begin
              ph_nxt               = scr_h_r[rom_data[2]];      // [RULE_05]
              scr_h_nxt[rom_data[2]] = ph_r;                    // [RULE_05]
            end
            OP_SWAP_PL_S0, OP_SWAP_PL_S1: begin
              pl_nxt               = scr_l_r[rom_data[2]];      // [RULE_05]
              scr_l_nxt[rom_data[2]] = pl_r;                    // [RULE_05]
            end
            OP_PAGE_JUMP: pc_nxt = {pc_r[11:8], ext_r, acc_r};  // [RULE_09]
            OP_SUB_RET: begin
              pop    = 1'b1;                                    // [RULE_12]
              pc_nxt = stack_top;                               // [RULE_12]
            end
            OP_IRQ_RET: begin
              pop       = 1'b1;                                 // [RULE_12]
              pc_nxt    = stack_top;                            // [RULE_12]
              carry_nxt = saved_carry;                          // [RULE_12]
              zero_nxt  = saved_zero;                           // [RULE_12]
            end
            OP_PORT_READ: begin
              acc_nxt  = port_rdata;                            // [RULE_18]
              zero_nxt = (port_rdata == NIB_ZERO);              // [RULE_18]
            end
            OP_PORT_WRITE: begin
              pwdata_nxt = acc_r;                               // [RULE_18]
              pwr_nxt    = 1'b1;                                // [RULE_18]
            end
            OP_TIMER_LOAD: begin
              tval_nxt = {ext_r, acc_r};                        // [RULE_21]
              twr_nxt  = 1'b1;                                  // [RULE_21]
              tick_nxt = 1'b0;                                  // [RULE_21]
            end
            OP_HALT: state_nxt = ST_HALT;                       // [RULE_22]
            // Idle and the arithmetic group left to other logic
            default: pc_nxt = pc_inc;                           // [RULE_22]
          endcase
        end
      end
    endcase
    // A new event wins over a clear in the same cycle
    tick_nxt = tick_nxt | tick_ovf;
    irq_nxt  = irq_nxt | irq_edge;
  end

  return_stack #(.DEPTH(STACK_LEVELS), .W(PC_W)) u_stack (      // [RULE_24]
    .clk_sys   (clk_sys),
    .reset     (reset),
    .push      (push & ce),
    .pop       (pop & ce),
    .push_data (push_val),
    .top       (stack_top)
  );

  general_flags u_flags (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .set_en     (fset & ce),
    .clr_en     (fclr & ce),
    .idx        (fidx),
    .flags      (gen_flags),
    .group_zero (group_zero)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_sync_r  <= '0;
      wake_sync_r <= '0;
    end else if (ce) begin
      irq_sync_r  <= {irq_sync_r[1:0], pin_irq};
      wake_sync_r <= {wake_sync_r[0], wake};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r <= ST_EXEC;
      pc_r    <= PC_RESET;
      first_r <= OP_IDLE;
      run_r   <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      first_r <= first_nxt;
      run_r   <= run_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_r   <= NIB_ZERO;
      ext_r   <= NIB_ZERO;
      ph_r    <= NIB_ZERO;
      pl_r    <= NIB_ZERO;
      scr_a_r <= '{default: NIB_ZERO};
      scr_h_r <= '{default: NIB_ZERO};
      scr_l_r <= '{default: NIB_ZERO};
    end else if (ce) begin
      acc_r   <= acc_nxt;
      ext_r   <= ext_nxt;
      ph_r    <= ph_nxt;
      pl_r    <= pl_nxt;
      scr_a_r <= scr_a_nxt;
      scr_h_r <= scr_h_nxt;
      scr_l_r <= scr_l_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      carry_r  <= 1'b0;
      zero_r   <= 1'b0;
      tick_r   <= 1'b0;
      irq_r    <= 1'b0;
      ctl_r    <= NIB_ZERO;
      pwdata_r <= NIB_ZERO;
      pwr_r    <= 1'b0;
      tval_r   <= 8'h00;
      twr_r    <= 1'b0;
    end else if (ce) begin
      carry_r  <= carry_nxt;
      zero_r   <= zero_nxt;
      tick_r   <= tick_nxt;
      irq_r    <= irq_nxt;
      ctl_r    <= ctl_nxt;
      pwdata_r <= pwdata_nxt;
      pwr_r    <= pwr_nxt;
      tval_r   <= tval_nxt;
      twr_r    <= twr_nxt;
    end
  end

  assign rom_addr           = pc_r;
  assign ram_addr           = {ph_r, pl_r};
  assign port_sel           = pl_r;
  assign port_wdata         = pwdata_r;
  // Strobe held while ce is low would repeat a write; gate it
  assign port_wr            = pwr_r & ce;
  assign timer_wr           = twr_r & ce;
  assign timer_value        = tval_r;
  assign control_bits       = ctl_r;
  assign halted             = (state_r == ST_HALT);
  assign tick_overflow_flag = tick_r;
  assign pin_irq_flag       = irq_r;
  assign carry_flag         = carry_r;
  assign zero_flag          = zero_r;
  assign work_nibble_reg    = acc_r;
endmodule : nibble_cpu_instruction_decoder

// *** verification/nibble_dec_chk_asserts.sv ***
// Port-level checks for the decoder.
// Assumes ce is held high by the surroundings.
module nibble_dec_chk (
  input wire logic        clk_sys, reset, ce, tick_ovf, pin_irq, wake,
  input wire logic        halted, tick_overflow_flag, pin_irq_flag, port_wr, timer_wr,
  input wire logic [11:0] rom_addr,
  input wire logic [7:0]  ram_addr, timer_value,
  input wire logic [3:0]  port_sel, work_nibble_reg,
  input wire logic [15:0] gen_flags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_tick_set: assert property (ce && tick_ovf && !halted |=> tick_overflow_flag) else $error("tick lost");
  a_timer_clear: assert property (timer_wr && !$past(tick_ovf) |-> !tick_overflow_flag) else $error("tick kept");
  a_timer_data: assert property (timer_wr |-> timer_value[3:0] == work_nibble_reg) else $error("timer low");
  a_halt_pc: assert property (halted && $past(halted) |-> $stable(rom_addr)) else $error("pc moved");
  a_halt_state: assert property (halted && $past(halted) |-> $stable({work_nibble_reg, gen_flags})) else $error("ran");
  a_port_ptr: assert property (port_wr |-> $stable(port_sel)) else $error("port select");
  a_pin_flag: assert property ($rose(pin_irq) && !halted |-> ##[1:5] pin_irq_flag) else $error("pin flag");
  a_wake_exit: assert property (halted && $rose(wake) |-> ##[1:5] !halted) else $error("no wake");
  c_port: cover property (port_wr);
  c_timer: cover property (timer_wr);
  c_wake: cover property ($fell(halted));
endmodule : nibble_dec_chk
bind nibble_cpu_instruction_decoder nibble_dec_chk chk (.clk_sys, .reset, .ce, .tick_ovf, .pin_irq, .wake, .halted,
  .tick_overflow_flag, .pin_irq_flag, .port_wr, .timer_wr, .rom_addr, .ram_addr, .timer_value, .port_sel,
  .work_nibble_reg, .gen_flags);

// *** verification/nibble_env_model.sv ***
// Program ROM, data RAM and port file for the decoder.
// Assumes the bench loads the ROM array before it pulses reset for each program.
module nibble_env_model (
  input  wire logic        clk_sys,
  input  wire logic [11:0] rom_addr,
  output logic      [7:0]  rom_data,
  input  wire logic [7:0]  ram_addr,
  output logic      [3:0]  ram_rdata,
  input  wire logic [3:0]  port_sel,
  output logic      [3:0]  port_rdata,
  input  wire logic [3:0]  port_wdata,
  input  wire logic        port_wr
);
  logic [7:0] rom [0:4095];
  logic [3:0] ram [0:255];
  logic [3:0] ports [0:15];
  assign rom_data   = rom[rom_addr];
  assign ram_rdata  = ram[ram_addr];
  assign port_rdata = ports[port_sel];
  always @(posedge clk_sys) if (port_wr) ports[port_sel] <= port_wdata;
endmodule : nibble_env_model

// *** verification/nibble_cpu_instruction_decoder_bench.sv ***
// Self-checking bench: ROM programs, reset, then port checks.
// Assumes ce always high; extension register resets to zero.
module nibble_cpu_instruction_decoder_bench
  import nibble_cpu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset = 1, tick_ovf = 0, pin_irq = 0, wake = 0;
  logic port_wr, timer_wr, halted, tick_overflow_flag, pin_irq_flag, carry_flag, zero_flag;
  logic [11:0] rom_addr;
  logic [7:0] rom_data, ram_addr, timer_value, p;
  logic [3:0] ram_rdata, port_sel, port_rdata, port_wdata, control_bits, work_nibble_reg, a, b;
  logic [15:0] gen_flags;
  int bad_count = 0, checks = 0, cyc = 0;
  nibble_cpu_instruction_decoder uut (.clk_sys, .reset, .ce(1'b1), .rom_addr, .rom_data, .ram_addr, .ram_rdata,
    .port_sel, .port_rdata, .port_wdata, .port_wr, .control_bits, .timer_value, .timer_wr, .tick_ovf,
    .saved_carry(1'b0), .saved_zero(1'b0), .pin_irq, .wake, .halted, .tick_overflow_flag, .pin_irq_flag,
    .carry_flag, .zero_flag, .work_nibble_reg, .gen_flags);
  nibble_env_model env (.clk_sys, .rom_addr, .rom_data, .ram_addr, .ram_rdata, .port_sel, .port_rdata,
    .port_wdata, .port_wr);
  function automatic logic grp_zero(input logic [15:0] f, input logic [3:0] i);
    return f[{i[3:2], 2'b00} +: 4] == 4'h0;
  endfunction : grp_zero
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic go(input int n);
    reset <= 1;
    repeat (4) @(posedge clk_sys);
    reset <= 0;
    repeat (n) @(posedge clk_sys);
  endtask : go
  task summarize;
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    void'($urandom(56515));
    a = 4'($urandom);
    b = 4'($urandom);
    env.rom = '{default: 8'h00};
    env.rom[0:5] = '{{NB_PTR_ZERO_HIGH, a}, {NB_PTR_HIGH_IMM, b}, OP_PTR_LOW_INC, OP_PL_TO_ACC, OP_PORT_WRITE, OP_HALT};
    go(12);
    chk("ram_addr", {b, a + 4'h1}, ram_addr);
    chk("acc", a + 4'h1, work_nibble_reg);
    chk("zero", (a + 4'h1) == 4'h0, zero_flag);
    chk("port", a + 4'h1, env.ports[a + 4'h1]);
    chk("halted", 1, halted);
    wake <= 1;
    repeat (6) @(posedge clk_sys);
    chk("woken", 0, halted);
    wake <= 0;
    // Tick arrives before the timer load, which must clear it
    env.rom = '{default: 8'h00};
    env.rom[3:8] = '{{NB_LOAD_IMM, a}, {NB_LOAD_IMM, ~a}, OP_TIMER_LOAD, OP_CTRL_PFX, {CTRL_SEL_SET, a}, OP_HALT};
    go(1);
    tick_ovf <= 1;
    @(posedge clk_sys);
    tick_ovf <= 0;
    repeat (10) @(posedge clk_sys);
    chk("acc run", a, work_nibble_reg);
    chk("timer", {4'h0, a}, timer_value);
    chk("tick", 0, tick_overflow_flag);
    chk("ctrl", a, control_bits);
    p = {2'b01, 6'($urandom)};
    env.rom = '{default: 8'h00};
    env.rom[0:3] = '{{NB_FLAG_SET, a}, {NB_FLAG_CLR, a ^ 4'h1}, {NB_BF_SET, p[7:4]}, {a, p[3:0]}};
    env.rom[p] = OP_HALT;
    go(12);
    chk("flags", 16'h1 << a, gen_flags);
    chk("group", grp_zero(16'h1 << a, a ^ 4'h1), zero_flag);
    chk("branch", 1, halted);
    env.rom = '{default: 8'h00};
    env.rom[0:1] = '{{NB_PAGE0_CALL, b | 4'h1}, OP_HALT};
    env.rom[{b | 4'h1, 2'b00}] = {NB_LOAD_IMM, b | 4'h1};
    env.rom[{b | 4'h1, 2'b01}] = OP_SUB_RET;
    go(10);
    chk("return", 1, halted);
    chk("sub acc", b | 4'h1, work_nibble_reg);
    chk("ret pc", 12'h002, rom_addr);
    env.rom = '{default: 8'h00};
    env.rom[8:9] = '{{NB_BR_ONE, 4'h3}, {BR_PIN_IRQ, 4'h0}};
    env.rom[12'h030] = OP_HALT;
    go(1);
    pin_irq <= 1;
    repeat (6) @(posedge clk_sys);
    chk("pin set", 1, pin_irq_flag);
    repeat (8) @(posedge clk_sys);
    chk("pin clr", 0, pin_irq_flag);
    chk("pin br", 1, halted);
    summarize();
  end
endmodule : nibble_cpu_instruction_decoder_bench
